// ==== verilog/osf_map.vh ====
// Purpose: Register map, field layout and timing constants of the timer block
// Assumes: 100 MHz i_clock, 32-bit AHB-Lite register bus
// Notes:   Included by both design files; definitions only
`ifndef OSF_MAP_VH
`define OSF_MAP_VH

// Register byte offsets, one aligned word each
`define OSF_ADDR_W          8
`define OSF_OFS_CTRL        8'h00
`define OSF_OFS_PULSE_SET   8'h04
`define OSF_OFS_PULSE_CUR   8'h08
`define OSF_OFS_ON_SET      8'h0C
`define OSF_OFS_ON_CUR      8'h10
`define OSF_OFS_OFF_SET     8'h14
`define OSF_OFS_OFF_CUR     8'h18
`define OSF_OFS_RUN_SET     8'h1C
`define OSF_OFS_RUN_CUR     8'h20
`define OSF_OFS_STATUS      8'h24

// Control register fields
`define OSF_CTRL_W          8
`define OSF_CTRL_RST        8'h00
`define OSF_CTRL_PUNIT      1:0
`define OSF_CTRL_PPRIO      2
`define OSF_CTRL_FUNIT      5:4
`define OSF_CTRL_FMODE      7:6

// Status register fields
`define OSF_STAT_PULSE      0
`define OSF_STAT_PATTERN    1

// Value widths and limits
`define OSF_VAL_W           15
`define OSF_VAL_ZERO        15'h0000
`define OSF_VAL_ONE         15'h0001
`define OSF_PAD_W           17
`define OSF_PAD_ZERO        17'h0_0000

// Time base unit codes
`define OSF_UNIT_10MS       2'h0
`define OSF_UNIT_100MS      2'h1
`define OSF_UNIT_1S         2'h2

// Pattern run modes
`define OSF_MODE_CONT       2'h0
`define OSF_MODE_CYCLE      2'h1
`define OSF_MODE_TIME       2'h2

// Time base: 10 ms at 100 MHz, then decimal dividers
`define OSF_CLK_HZ          100000000
`define OSF_BASE_MS         10
`define OSF_CYC_10MS        20'hF_4240
`define OSF_PRE_W           20
`define OSF_PRE_ONE         20'h0_0001
`define OSF_PRE_ZERO        20'h0_0000
`define OSF_DIV_W           7
`define OSF_DIV_1           7'h01
`define OSF_DIV_10          7'h0A
`define OSF_DIV_100         7'h64
`define OSF_DIV_ZERO        7'h00
`define OSF_DIV_ONE         7'h01

// AHB-Lite encodings
`define OSF_HTRANS_NONSEQ   1
`define OSF_WORD_ZERO       32'h0000_0000

`endif

// ==== verilog/osf_tick.v ====
// Purpose: Time base tick generator, one tick per 10 ms, 100 ms or 1 s
// Assumes: i_restart realigns the tick to the start of a timed interval
// Notes:   10 ms prescale count is a parameter so simulation can shorten it
`include "osf_map.vh"
`default_nettype none

module osf_tick #(
	parameter [`OSF_PRE_W-1:0] CYC_10MS = `OSF_CYC_10MS
) (
	input  wire       i_clock,
	input  wire       i_reset,
	input  wire       i_restart,
	input  wire [1:0] i_unit,
	output reg        o_tick
);

	reg  [`OSF_PRE_W-1:0] pre_reg;
	reg  [`OSF_DIV_W-1:0] div_reg;
	reg  [`OSF_DIV_W-1:0] div_limit;
	wire                  pre_wrap;

	// Code 3 is unused and falls back to the 1 s unit
	always @* begin
		case (i_unit)
			`OSF_UNIT_10MS:  div_limit = `OSF_DIV_1;
			`OSF_UNIT_100MS: div_limit = `OSF_DIV_10;
			default:         div_limit = `OSF_DIV_100;
		endcase
	end

	assign pre_wrap = (pre_reg == CYC_10MS - `OSF_PRE_ONE);

	// Prescaler and decade divider; restart zeroes both
	always @(posedge i_clock) begin
		if (i_reset || i_restart) begin
			pre_reg <= `OSF_PRE_ZERO;
			div_reg <= `OSF_DIV_ZERO;
			o_tick  <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (pre_wrap) begin
				pre_reg <= `OSF_PRE_ZERO;
				if (div_reg + `OSF_DIV_ONE >= div_limit) begin
					div_reg <= `OSF_DIV_ZERO;
					o_tick  <= 1'b1;
				end else begin
					div_reg <= div_reg + `OSF_DIV_ONE;
				end
			end else begin
				pre_reg <= pre_reg + `OSF_PRE_ONE;
			end
		end
	end

endmodule // osf_tick
`default_nettype wire

// ==== verilog/osf_timer.v ====
// Purpose: Single-pulse timer and on/off pattern generator with AHB-Lite registers
// Assumes: Trigger, clear and pattern inputs arrive from pins, asynchronous
// Notes:   Zero-wait-state slave; all durations count in the selected unit
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`include "osf_map.vh"
`default_nettype none

// Overview of operation
// R1 - Each timer counts in a selectable unit of 10 ms, 100 ms or 1 s.
// R2 - Pulse duration setting accepts 0 to 32767 units.
// R3 - Trigger starts one pulse lasting exactly the set duration.
// R4 - Clear forces pulse output off at once, overriding the trigger.
// R5 - Zero duration makes the pulse timer act as a plain one-cycle pulse.
// R6 - Priority setting chooses time priority or input priority for pulse end.
// R7 - Pulse setting and elapsed count are readable by other blocks.
// R8 - Pattern on-phase duration accepts 0 to 32767 units.
// R9 - Pattern off-phase duration accepts 0 to 32767, set independently.
// R10 - Pattern output alternates between on and off phases.
// R11 - Cycle mode runs a preset number of on/off cycles, up to 32767.
// R12 - Time mode runs the pattern for a preset total time, up to 32767.
// R13 - Continuous mode runs the pattern only while the input is on.
// R14 - Pattern settings and current values are readable by other blocks.
// R15 - Software keeps every set time at least one evaluation interval long.
// R16 - Pulse starts on trigger rising edge; each pattern run starts on-phase.
module osf_timer #(
	parameter [`OSF_PRE_W-1:0] CYC_10MS = `OSF_CYC_10MS
) (
	input  wire        i_clock,
	input  wire        i_reset,
	input  wire        i_hsel,
	input  wire [31:0] i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output wire        o_hreadyout,
	output wire        o_hresp,
	output reg  [31:0] o_hrdata,
	input  wire        i_pulse_trigger,
	input  wire        i_pulse_clear,
	input  wire        i_pattern_input,
	output reg         o_pulse_out,
	output reg         o_pattern_out
);

	localparam [1:0] P_IDLE = 2'b01;
	localparam [1:0] P_ON   = 2'b10;
	localparam [2:0] F_IDLE = 3'b001;
	localparam [2:0] F_ON   = 3'b010;
	localparam [2:0] F_OFF  = 3'b100;

	reg  [2:0]            sync1_reg;
	reg  [2:0]            sync2_reg;
	reg  [2:0]            sync3_reg;
	reg  [2:0]            level_reg;
	reg  [2:0]            level_d_reg;
	reg  [`OSF_CTRL_W-1:0] ctrl_reg;
	reg  [`OSF_VAL_W-1:0] pulse_set_reg;
	reg  [`OSF_VAL_W-1:0] on_set_reg;
	reg  [`OSF_VAL_W-1:0] off_set_reg;
	reg  [`OSF_VAL_W-1:0] run_set_reg;
	reg  [`OSF_VAL_W-1:0] pulse_cnt_reg;
	reg  [`OSF_VAL_W-1:0] on_cnt_reg;
	reg  [`OSF_VAL_W-1:0] off_cnt_reg;
	reg  [`OSF_VAL_W-1:0] run_cnt_reg;
	reg  [1:0]            p_state_reg;
	reg  [2:0]            f_state_reg;
	reg  [2:0]            f_state_next;
	reg  [`OSF_VAL_W-1:0] on_cnt_next;
	reg  [`OSF_VAL_W-1:0] off_cnt_next;
	reg  [`OSF_VAL_W-1:0] run_cnt_next;
	reg                   wr_pend_reg;
	reg  [`OSF_ADDR_W-1:0] wr_addr_reg;
	reg  [31:0]           rd_word;
	wire                  bus_take;
	wire                  trig_lvl;
	wire                  clr_lvl;
	wire                  pin_lvl;
	wire                  trig_rise;
	wire                  pin_rise;
	wire                  pulse_tick;
	wire                  pattern_tick;
	wire                  pulse_start;
	wire                  run_start;
	wire [1:0]            run_mode;

	// Three-stage sync; a level change counts once stages two and three agree
	always @(posedge i_clock) begin
		if (i_reset) begin
			sync1_reg   <= 3'h0;
			sync2_reg   <= 3'h0;
			sync3_reg   <= 3'h0;
			level_reg   <= 3'h0;
			level_d_reg <= 3'h0;
		end else begin
			sync1_reg   <= {i_pattern_input, i_pulse_clear, i_pulse_trigger};
			sync2_reg   <= sync1_reg;
			sync3_reg   <= sync2_reg;
			level_reg   <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg ^ sync3_reg));
			level_d_reg <= level_reg;
		end
	end

	assign trig_lvl  = level_reg[0];
	assign clr_lvl   = level_reg[1];
	assign pin_lvl   = level_reg[2];
	assign trig_rise = level_reg[0] & ~level_d_reg[0];
	assign pin_rise  = level_reg[2] & ~level_d_reg[2];
	assign run_mode  = ctrl_reg[`OSF_CTRL_FMODE];

	// Pulse tick is realigned at each start so the duration is exact
	assign pulse_start = (p_state_reg == P_IDLE) && trig_rise && !clr_lvl;

	osf_tick #(.CYC_10MS(CYC_10MS)) u_pulse_tick (
		.i_clock   (i_clock),
		.i_reset   (i_reset),
		.i_restart (pulse_start),
		.i_unit    (ctrl_reg[`OSF_CTRL_PUNIT]),
		.o_tick    (pulse_tick)
	); // see R1

	osf_tick #(.CYC_10MS(CYC_10MS)) u_pattern_tick (
		.i_clock   (i_clock),
		.i_reset   (i_reset),
		.i_restart (run_start),
		.i_unit    (ctrl_reg[`OSF_CTRL_FUNIT]),
		.o_tick    (pattern_tick)
	); // see R1

	// Single-pulse timer; clear is checked first so it always wins
	always @(posedge i_clock) begin
		if (i_reset) begin
			p_state_reg   <= P_IDLE;
			pulse_cnt_reg <= `OSF_VAL_ZERO;
			o_pulse_out   <= 1'b0;
		end else if (clr_lvl) begin
			p_state_reg   <= P_IDLE; // see R4
			pulse_cnt_reg <= `OSF_VAL_ZERO;
			o_pulse_out   <= 1'b0;
		end else begin
			case (p_state_reg)
				P_IDLE: begin
					o_pulse_out <= 1'b0;
					if (pulse_start) begin // see R16
						pulse_cnt_reg <= `OSF_VAL_ZERO;
						o_pulse_out   <= 1'b1;
						if (pulse_set_reg != `OSF_VAL_ZERO)
							p_state_reg <= P_ON; // see R3
						// Zero set time gives a single-cycle pulse, see R5
					end
				end
				P_ON: begin
					// Input priority ends the pulse as soon as the trigger drops
					if (ctrl_reg[`OSF_CTRL_PPRIO] && !trig_lvl) begin // see R6
						p_state_reg <= P_IDLE;
						o_pulse_out <= 1'b0;
					end else if (pulse_tick) begin
						pulse_cnt_reg <= pulse_cnt_reg + `OSF_VAL_ONE; // see R7
						if (pulse_cnt_reg + `OSF_VAL_ONE >= pulse_set_reg) begin // see R3
							p_state_reg <= P_IDLE;
							o_pulse_out <= 1'b0;
						end
					end
				end
				default: begin
					p_state_reg <= P_IDLE;
					o_pulse_out <= 1'b0;
				end
			endcase
		end
	end

	// A run starts on input level (continuous) or input rising edge (counted)
	assign run_start = (f_state_reg == F_IDLE) &&
		((run_mode == `OSF_MODE_CONT) ? pin_lvl :
		 (pin_rise && run_set_reg != `OSF_VAL_ZERO)); // see R13

	// Pattern generator next state; a zero-length phase is skipped at once
	always @* begin
		f_state_next = f_state_reg;
		on_cnt_next  = on_cnt_reg;
		off_cnt_next = off_cnt_reg;
		run_cnt_next = run_cnt_reg;
		case (f_state_reg)
			F_IDLE: begin
				if (run_start) begin
					f_state_next = F_ON; // see R16
					on_cnt_next  = `OSF_VAL_ZERO;
					off_cnt_next = `OSF_VAL_ZERO;
					run_cnt_next = `OSF_VAL_ZERO;
				end
			end
			F_ON: begin
				if (pattern_tick)
					on_cnt_next = on_cnt_reg + `OSF_VAL_ONE;
				if (on_set_reg == `OSF_VAL_ZERO ||
				    (pattern_tick && on_cnt_next >= on_set_reg)) begin // see R8
					f_state_next = F_OFF; // see R10
					off_cnt_next = `OSF_VAL_ZERO;
				end
			end
			F_OFF: begin
				if (pattern_tick)
					off_cnt_next = off_cnt_reg + `OSF_VAL_ONE;
				if (off_set_reg == `OSF_VAL_ZERO ||
				    (pattern_tick && off_cnt_next >= off_set_reg)) begin // see R9
					f_state_next = F_ON; // see R10
					on_cnt_next  = `OSF_VAL_ZERO;
					if (run_mode == `OSF_MODE_CYCLE) begin
						run_cnt_next = run_cnt_reg + `OSF_VAL_ONE;
						if (run_cnt_next >= run_set_reg)
							f_state_next = F_IDLE; // see R11
					end
				end
			end
			default: f_state_next = F_IDLE;
		endcase
		// Time mode counts total elapsed units across both phases
		if (f_state_reg != F_IDLE && run_mode == `OSF_MODE_TIME && pattern_tick) begin
			run_cnt_next = run_cnt_reg + `OSF_VAL_ONE;
			if (run_cnt_next >= run_set_reg)
				f_state_next = F_IDLE; // see R12
		end
		// Continuous mode follows the input level
		if (f_state_reg != F_IDLE && run_mode == `OSF_MODE_CONT && !pin_lvl)
			f_state_next = F_IDLE; // see R13
	end

	// Both phases zero leaves the output off instead of chattering
	always @(posedge i_clock) begin
		if (i_reset) begin
			f_state_reg   <= F_IDLE;
			on_cnt_reg    <= `OSF_VAL_ZERO;
			off_cnt_reg   <= `OSF_VAL_ZERO;
			run_cnt_reg   <= `OSF_VAL_ZERO;
			o_pattern_out <= 1'b0;
		end else begin
			f_state_reg   <= f_state_next;
			on_cnt_reg    <= on_cnt_next;
			off_cnt_reg   <= off_cnt_next;
			run_cnt_reg   <= run_cnt_next;
			o_pattern_out <= (f_state_next == F_ON) && (on_set_reg != `OSF_VAL_ZERO);
		end
	end

	// AHB-Lite slave: never stalls, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign bus_take    = i_hsel && i_hready && i_htrans[`OSF_HTRANS_NONSEQ];

	// Read mux by address-phase address; unmapped reads give zero
	always @* begin
		case (i_haddr[`OSF_ADDR_W-1:0])
			`OSF_OFS_CTRL:      rd_word = {24'h00_0000, ctrl_reg};
			`OSF_OFS_PULSE_SET: rd_word = {`OSF_PAD_ZERO, pulse_set_reg}; // see R7
			`OSF_OFS_PULSE_CUR: rd_word = {`OSF_PAD_ZERO, pulse_cnt_reg}; // see R7
			`OSF_OFS_ON_SET:    rd_word = {`OSF_PAD_ZERO, on_set_reg};    // see R14
			`OSF_OFS_ON_CUR:    rd_word = {`OSF_PAD_ZERO, on_cnt_reg};    // see R14
			`OSF_OFS_OFF_SET:   rd_word = {`OSF_PAD_ZERO, off_set_reg};   // see R14
			`OSF_OFS_OFF_CUR:   rd_word = {`OSF_PAD_ZERO, off_cnt_reg};   // see R14
			`OSF_OFS_RUN_SET:   rd_word = {`OSF_PAD_ZERO, run_set_reg};   // see R14
			`OSF_OFS_RUN_CUR:   rd_word = {`OSF_PAD_ZERO, run_cnt_reg};   // see R14
			`OSF_OFS_STATUS:    rd_word = {30'h0000_0000, o_pattern_out, o_pulse_out};
			default:            rd_word = `OSF_WORD_ZERO;
		endcase
	end

	// Address phase latch and read data; write lands in the data phase
	always @(posedge i_clock) begin
		if (i_reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= `OSF_OFS_CTRL;
			o_hrdata    <= `OSF_WORD_ZERO;
		end else begin
			wr_pend_reg <= bus_take && i_hwrite;
			if (bus_take) begin
				wr_addr_reg <= i_haddr[`OSF_ADDR_W-1:0];
				if (!i_hwrite)
					o_hrdata <= rd_word;
			end
		end
	end

	// Writable settings; each duration keeps the low 15 bits of the written word and control the low 8, higher bits are dropped
	always @(posedge i_clock) begin
		if (i_reset) begin
			ctrl_reg      <= `OSF_CTRL_RST;
			pulse_set_reg <= `OSF_VAL_ZERO;
			on_set_reg    <= `OSF_VAL_ZERO;
			off_set_reg   <= `OSF_VAL_ZERO;
			run_set_reg   <= `OSF_VAL_ZERO;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				`OSF_OFS_CTRL:      ctrl_reg      <= i_hwdata[`OSF_CTRL_W-1:0];
				`OSF_OFS_PULSE_SET: pulse_set_reg <= i_hwdata[`OSF_VAL_W-1:0]; // see R2
				`OSF_OFS_ON_SET:    on_set_reg    <= i_hwdata[`OSF_VAL_W-1:0]; // see R8
				`OSF_OFS_OFF_SET:   off_set_reg   <= i_hwdata[`OSF_VAL_W-1:0]; // see R9
				`OSF_OFS_RUN_SET:   run_set_reg   <= i_hwdata[`OSF_VAL_W-1:0]; // see R11
				default:            ctrl_reg      <= ctrl_reg;
			endcase
		end
	end

endmodule // osf_timer
`default_nettype wire

// ==== verif/osf_timer_sva.sv ====
// Purpose: Port-level assertions for the timer block
// Assumes: One clock, synchronous active-high reset
// Notes:   Shadows CTRL and PULSE_SET writes, since the bodies are not visible
`default_nettype none
module osf_timer_sva #(
	parameter logic [19:0] CYC_10MS = 20'h0_000A
) (
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic [31:0] o_hrdata,
	input wire logic        i_pulse_trigger,
	input wire logic        i_pulse_clear,
	input wire logic        i_pattern_input,
	input wire logic        o_pulse_out,
	input wire logic        o_pattern_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        take;
	logic        wr_reg;
	logic [7:0]  adr_reg;
	logic [7:0]  ctrl_reg;
	logic [14:0] pset_reg;
	logic [31:0] hi_cnt_reg;
	logic        clr_seen_reg;
	logic [31:0] unit_cyc;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);
	// Transfer taken and clock count of one unit
	assign take = i_hsel && i_hready && i_htrans[1];
	assign unit_cyc = (ctrl_reg[1:0] == 2'h0) ? CYC_10MS :
		(ctrl_reg[1:0] == 2'h1) ? CYC_10MS * 10 : CYC_10MS * 100;
	// Settings shadow and pulse length counter; a clear spoils the length check
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			wr_reg <= 1'b0;
			adr_reg <= 8'h00;
			ctrl_reg <= 8'h00;
			pset_reg <= 15'h0000;
			hi_cnt_reg <= 32'h0000_0000;
			clr_seen_reg <= 1'b0;
		end else begin
			wr_reg <= take && i_hwrite;
			adr_reg <= i_haddr[7:0];
			if (wr_reg && adr_reg == 8'h00) begin
				ctrl_reg <= i_hwdata[7:0];
			end
			if (wr_reg && adr_reg == 8'h04) begin
				pset_reg <= i_hwdata[14:0];
			end
			hi_cnt_reg <= o_pulse_out ? hi_cnt_reg + 1 : 32'h0000_0000;
			clr_seen_reg <= o_pulse_out && (clr_seen_reg || i_pulse_clear);
		end
	end
	sequence s_rd_gap;
		take && !i_hwrite && i_haddr[7:0] > 8'h27;
	endsequence
	sequence s_clear_held;
		i_pulse_clear [*8];
	endsequence
	bus_okay_a:
	assert property (o_hreadyout && !o_hresp) else $error("bus not ready or not okay");
	gap_zero_a:
	assert property (s_rd_gap |=> o_hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	rdata_hold_a:
	assert property (!(take && !i_hwrite) |=> $stable(o_hrdata))
		else $error("read data moved without a read");
	clear_wins_a:
	assert property (s_clear_held |-> !o_pulse_out) else $error("pulse on while clear held");
	pulse_cause_a:
	assert property ($rose(o_pulse_out) |-> $past(i_pulse_trigger, 2))
		else $error("pulse without trigger");
	pulse_len_a:
	assert property ($fell(o_pulse_out) && !ctrl_reg[2] && !clr_seen_reg
		|-> hi_cnt_reg == pset_reg * unit_cyc + 1) else $error("pulse length wrong");
	input_prio_a:
	assert property ((ctrl_reg[2] && !i_pulse_trigger) [*8] |-> !o_pulse_out)
		else $error("pulse outlived trigger");
	follow_input_a:
	assert property ((ctrl_reg[7:6] == 2'h0 && !i_pattern_input) [*8] |-> !o_pattern_out)
		else $error("pattern on without input");
endmodule // osf_timer_sva
bind osf_timer osf_timer_sva #(.CYC_10MS(CYC_10MS)) i_sva (.i_clock(i_clock),
	.i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
	.i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
	.i_pulse_trigger(i_pulse_trigger), .i_pulse_clear(i_pulse_clear),
	.i_pattern_input(i_pattern_input), .o_pulse_out(o_pulse_out),
	.o_pattern_out(o_pattern_out));
`default_nettype wire

// ==== verif/osf_pins.sv ====
// Purpose: Upstream program blocks driving the three timer pins
// Assumes: Requests come from the bench just after a rising edge
// Notes:   Levels change only once per pass, like a scanned program
`default_nettype none
module osf_pins (
	input  wire logic i_clock,
	input  wire logic i_trig_req,
	input  wire logic i_clr_req,
	input  wire logic i_in_req,
	output var  logic o_trig,
	output var  logic o_clr,
	output var  logic o_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Known low from time zero, so the timer never sees an unknown pin
	initial begin
		o_trig = 1'b0;
		o_clr = 1'b0;
		o_in = 1'b0;
	end
	// Held a whole pass, never shorter than one evaluation interval
	always @(posedge i_clock) begin
		o_trig <= i_trig_req;
		o_clr <= i_clr_req;
		o_in <= i_in_req;
	end
endmodule // osf_pins
`default_nettype wire

// ==== verif/one_shot_and_flicker_timer_test.sv ====
// Purpose: Self-checking bench for the single-pulse timer and pattern generator
// Assumes: Prescale shortened to ten clocks per 10 ms unit
// Notes:   Register shadow and timing expectations are worked out here
`default_nettype none
module one_shot_and_flicker_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] CYC = 20'h0_000A;
	localparam logic [31:0] Z = 32'h0000_0000;
	logic        clk, rst, hsel, hwrite, t_req, c_req, p_req, trig, clr, pin;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, rd;
	logic [31:0] shadow [0:63];
	wire         hready, hresp, pout, fout;
	wire  [31:0] hrdata;
	int          n_mismatch = 0, n_compared = 0, cyc = 0, len, w, r, u;
	osf_timer #(.CYC_10MS(CYC)) i_dut (.i_clock(clk), .i_reset(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_pulse_trigger(trig), .i_pulse_clear(clr),
		.i_pattern_input(pin), .o_pulse_out(pout), .o_pattern_out(fout));
	osf_pins i_pins (.i_clock(clk), .i_trig_req(t_req), .i_clr_req(c_req), .i_in_req(p_req),
		.o_trig(trig), .o_clr(clr), .o_in(pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard; the full run needs well under a tenth of this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One single-word transfer; no wait count assumed, hready decides
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Write that also updates the model; settings keep 15 bits, control 8
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		shadow[a[7:2]] = d & ((a == 8'h00) ? 32'h0000_00FF : 32'h0000_7FFF);
	endtask
	task automatic pins(input logic t, input logic c, input logic p);
		@(posedge clk);
		t_req <= t;
		c_req <= c;
		p_req <= p;
	endtask
	// Wait for an output to reach a level, then count how long it stays
	// Sampled at the falling edge, where registered outputs have settled
	task automatic measure(input bit sel, input logic lvl, output int k, output int n);
		k = 0;
		n = 0;
		while ((sel ? fout : pout) !== lvl && k < 3000) begin
			@(negedge clk);
			k++;
		end
		while ((sel ? fout : pout) === lvl && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Counted run: input pulsed briefly, rises and high cycles tallied
	task automatic run_count(output int rises, output int highs);
		logic prev;
		prev = 1'b0;
		rises = 0;
		highs = 0;
		pins(1'b0, 1'b0, 1'b1);
		fork
			begin
				repeat (12) @(posedge clk);
				pins(1'b0, 1'b0, 1'b0);
			end
			repeat (300) begin
				@(negedge clk);
				rises += (fout === 1'b1 && prev === 1'b0);
				highs += (fout === 1'b1);
				prev = fout;
			end
		join
	endtask
	initial begin
		{hsel, hwrite, t_req, c_req, p_req} = 5'h00;
		htrans = 2'h0;
		haddr = Z;
		hwdata = Z;
		rst = 1'b1;
		foreach (shadow[i]) shadow[i] = Z;
		void'($urandom(32'h71e5));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Every word of the map reads zero after reset, unmapped ones included
		for (int a = 0; a < 64; a++) begin
			xfer(1'b0, 8'(a * 4), Z);
			check($sformatf("reset %0d", a), rd, Z);
		end
		// Random settings round-trip through the register bus
		for (int a = 0; a < 8; a += 1 + (a > 0)) begin
			wr(8'(a * 4), (a == 0) ? ($urandom() & 32'h0000_003F) : $urandom());
			xfer(1'b0, 8'(a * 4), Z);
			check($sformatf("setting %0d", a), rd, shadow[a]);
		end
		xfer(1'b1, 8'h08, $urandom());
		xfer(1'b0, 8'h08, Z);
		check("elapsed ro", rd, Z);
		// One pulse per unit code 0 to 2, then a zero-setting pulse at code 0
		for (int i = 0; i < 4; i++) begin
			u = (i == 3) ? 0 : i;
			wr(8'h00, u);
			wr(8'h04, 3 - i);
			pins(1'b1, 1'b0, 1'b0);
			measure(1'b0, 1'b1, w, len);
			check("pulse len", len, (3 - i) * CYC * (10 ** u) + 1);
			pins(1'b0, 1'b0, 1'b0);
			repeat (8) @(posedge clk);
			xfer(1'b0, 8'h08, Z);
			check("pulse elapsed", rd, 3 - i);
		end
		// Clear in mid-pulse, then a trigger while clear still holds
		wr(8'h00, Z);
		wr(8'h04, 32'h0000_0005);
		pins(1'b1, 1'b0, 1'b0);
		repeat (20) @(negedge clk);
		check("pulse on", pout, 1'b1);
		xfer(1'b0, 8'h24, Z);
		check("status pulse", rd, 32'h0000_0001);
		pins(1'b1, 1'b1, 1'b0);
		repeat (9) @(negedge clk);
		check("cleared", pout, 1'b0);
		pins(1'b0, 1'b1, 1'b0);
		repeat (8) @(posedge clk);
		pins(1'b1, 1'b1, 1'b0);
		repeat (12) @(negedge clk);
		check("blocked", pout, 1'b0);
		xfer(1'b0, 8'h08, Z);
		check("elapsed cleared", rd, Z);
		pins(1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		// Input priority: dropping the trigger ends a ten-unit pulse early
		wr(8'h00, 32'h0000_0004);
		wr(8'h04, 32'h0000_000A);
		pins(1'b1, 1'b0, 1'b0);
		fork
			begin
				repeat (33) @(posedge clk);
				pins(1'b0, 1'b0, 1'b0);
			end
			measure(1'b0, 1'b1, w, len);
		join
		check("prio len", (len + 5) / 10, 3);
		// Continuous pattern, every phase at least one unit long
		wr(8'h00, Z);
		wr(8'h0C, 3);
		wr(8'h14, 2);
		pins(1'b0, 1'b0, 1'b1);
		measure(1'b1, 1'b1, w, len);
		check("starts on", w <= 8, 1'b1);
		check("on len", (len + 5) / 10, 3);
		measure(1'b1, 1'b0, w, len);
		check("off len", (len + 5) / 10, 2);
		measure(1'b1, 1'b1, w, len);
		check("on again", (len + 5) / 10, 3);
		pins(1'b0, 1'b0, 1'b0);
		repeat (12) @(negedge clk);
		check("input off", fout, 1'b0);
		// Cycle-count run of three, input dropped early and ignored
		wr(8'h00, 32'h0000_0040);
		wr(8'h1C, 3);
		wr(8'h0C, 1);
		wr(8'h14, 1);
		run_count(r, len);
		check("cycle rises", r, 3);
		check("cycle highs", (len + 5) / 10, 3);
		// Time-count run of five units: on 2, off 1, on 2
		wr(8'h00, 32'h0000_0080);
		wr(8'h1C, 5);
		wr(8'h0C, 2);
		run_count(r, len);
		check("time rises", r, 2);
		check("time highs", (len + 5) / 10, 4);
		print_verdict();
	end
endmodule // one_shot_and_flicker_timer_test
`default_nettype wire
